// [rtl/san_agg_pkg.sv]
package san_agg_pkg;
	// ----------------------------------------
	// client ports and trunk
	// ----------------------------------------
	localparam int NPORT = 8;
	localparam int RATE_W = 15;
	localparam logic [RATE_W-1:0] TRUNK_CAP_MBPS = 15'd2500;
	localparam int CLK_PERIOD_NS = 10;
	localparam int LOS_TIME_NS = 10000;
	localparam int LOS_CYCLES = LOS_TIME_NS / CLK_PERIOD_NS;
	localparam int LOS_W = 11;

	// ----------------------------------------
	// operating modes and client protocols
	// ----------------------------------------
	typedef enum logic [2:0] {
		MODE_FC_GE = 3'b001,
		MODE_MIXED = 3'b010,
		MODE_ALL_LRMC = 3'b100
	} mode_e;

	typedef enum logic [2:0] {
		PROTO_NONE = 3'h0,
		PROTO_GE = 3'h1,
		PROTO_FC1 = 3'h2,
		PROTO_FC2 = 3'h3,
		PROTO_MFFC1 = 3'h4,
		PROTO_MFFC2 = 3'h5,
		PROTO_LRMC = 3'h6
	} proto_e;

	localparam logic [RATE_W-1:0] RATE_GE = 15'd1250;
	localparam logic [RATE_W-1:0] RATE_1G = 15'd1060;
	localparam logic [RATE_W-1:0] RATE_2G = 15'd2125;
	localparam logic [RATE_W-1:0] RATE_LRMC = 15'd200;

	// trunk channel tags
	localparam logic [1:0] CHAN_STS24_A = 2'h0;
	localparam logic [1:0] CHAN_STS24_B = 2'h1;
	localparam logic [1:0] CHAN_GFPT = 2'h2;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic [1:0] chan;
		logic [2:0] port;
		logic [9:0] code;
	} cell_s;

	typedef struct packed {
		logic valid;
		logic frameOk;
		logic [2:0] port;
		logic [9:0] code;
	} rxword_s;

	typedef struct packed {
		logic valid;
		logic [9:0] code;
	} lane_s;
endpackage

// [rtl/san_client_aggregator.sv]
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - all-low-rate mode: all eight ports carry the low-rate mainframe channel
// - mixed mode: port 1 FC/GE/mainframe fibre, ports 5-8 low-rate channel
// - accept only client mixes whose summed rate fits the 2.5 Gbps trunk
// - 8B/10B clients are carried transparently in generic framing cells
// - in FC/GE mode, 1 Gbps traffic on port 1 or 2 maps to an STS-24c channel; in other modes it goes in GFP-T cells
// - port 1 goes to the first STS-24c channel, port 2 to the second
// - both STS-24c channels are combined into one OC-48 trunk stream
// - ports 1 and 2 take GE, FC, mainframe fibre or low-rate channel
// - ports 3 to 8 take the low-rate mainframe channel only
// - cells pass to the framer over a UTOPIA-style cell port
// - received trunk words are demapped toward the client ports
// - protected variant has two OC-48 trunk receive ports
// - both receive chains are monitored continuously and independently
// - a selector routes exactly one receive path to the clients
module san_client_aggregator import san_agg_pkg::*; #(
	parameter int PROTECTED = 1
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [2:0] cfgMode,
	input wire logic [NPORT-1:0][2:0] cfgProto,
	input wire logic cfgApply,
	input wire logic [NPORT-1:0] clientRxValid,
	input wire logic [NPORT-1:0][9:0] clientRxCode,
	output logic [NPORT-1:0] clientTxValid,
	output logic [NPORT-1:0][9:0] clientTxCode,
	output cell_s utTxCell,
	input wire logic utTxClav,
	input wire rxword_s trunkRxWork,
	input wire rxword_s trunkRxProt,
	input wire logic pathSelProt,
	output logic [1:0] pathAlive,
	output logic [NPORT-1:0] portEnable,
	output logic [2:0] activeMode,
	output logic cfgRejected
);
	if (PROTECTED != 0 && PROTECTED != 1) begin : gChk
		$error("PROTECTED must be 0 or 1");
	end
	// the loss timer must be wide enough to reach its limit
	if (LOS_CYCLES < 1 || LOS_CYCLES > (1 << LOS_W)) begin : gLosChk
		$error("LOS_W too narrow for LOS_CYCLES");
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [RATE_W-1:0] rateOf(input logic [2:0] p);
		unique case (p)
			PROTO_GE: rateOf = RATE_GE;
			PROTO_FC1, PROTO_MFFC1: rateOf = RATE_1G;
			PROTO_FC2, PROTO_MFFC2: rateOf = RATE_2G;
			PROTO_LRMC: rateOf = RATE_LRMC;
			default: rateOf = '0;
		endcase
	endfunction

	function automatic logic isOneGig(input logic [2:0] p);
		isOneGig = (p == PROTO_GE) || (p == PROTO_FC1) || (p == PROTO_MFFC1);
	endfunction

	function automatic logic [2:0] nextPort(input logic [NPORT-1:0] req,
		input logic [2:0] last);
		logic [2:0] idx;
		nextPort = last;
		for (int k = NPORT; k >= 1; k--) begin
			idx = 3'(int'(last) + k);
			if (req[idx]) begin
				nextPort = idx;
			end
		end
	endfunction

	// ----------------------------------------
	// configuration check
	// ----------------------------------------
	logic [RATE_W-1:0] rateSum;
	wire logic [NPORT-1:0] portLegal;
	logic modeLegal;
	logic cfgOk;

	always_comb begin
		rateSum = '0;
		for (int i = 0; i < NPORT; i++) begin
			rateSum = rateSum + rateOf(cfgProto[i]);
		end
	end

	for (genvar g = 0; g < NPORT; g++) begin : gLegal
		wire logic [2:0] pr = cfgProto[g];
		wire logic isLow = (pr == PROTO_LRMC);
		wire logic isNone = (pr == PROTO_NONE);
		wire logic fcGeOk = (g < 2) ? (pr <= PROTO_LRMC) : (isLow || isNone);
		wire logic mixOk = (g == 0) ? isOneGig(pr) :
			(g >= 4) ? isLow : isNone;
		assign portLegal[g] = (cfgMode == MODE_FC_GE) ? fcGeOk :
			(cfgMode == MODE_MIXED) ? mixOk :
			(cfgMode == MODE_ALL_LRMC) ? isLow : 1'b0;
	end

	assign modeLegal = (cfgMode == MODE_FC_GE) || (cfgMode == MODE_MIXED) ||
		(cfgMode == MODE_ALL_LRMC);
	// an illegal mix is refused whole so the trunk never oversubscribes
	assign cfgOk = modeLegal && (&portLegal) && (rateSum <= TRUNK_CAP_MBPS);

	logic [NPORT-1:0][2:0] proto_q;
	logic [2:0] mode_q;
	logic rej_q;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			proto_q <= '0;
			mode_q <= MODE_FC_GE;
			rej_q <= 1'b0;
		end else if (cfgApply) begin
			rej_q <= !cfgOk;
			if (cfgOk) begin
				proto_q <= cfgProto;
				mode_q <= cfgMode;
			end
		end
	end

	wire logic [NPORT-1:0] enNow;
	for (genvar g = 0; g < NPORT; g++) begin : gEn
		assign enNow[g] = (proto_q[g] != PROTO_NONE);
	end

	// ----------------------------------------
	// client input synchronisers
	// ----------------------------------------
	// only the second and third flops feed the word detect, so a half-settled code is never judged
	lane_s [NPORT-1:0] rxMeta_q;
	lane_s [NPORT-1:0] rxSync_q;
	lane_s [NPORT-1:0] rxPrev_q;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rxMeta_q <= '0;
			rxSync_q <= '0;
			rxPrev_q <= '0;
		end else begin
			for (int i = 0; i < NPORT; i++) begin
				rxMeta_q[i] <= '{valid: clientRxValid[i], code: clientRxCode[i]};
			end
			rxSync_q <= rxMeta_q;
			rxPrev_q <= rxSync_q;
		end
	end

	// ----------------------------------------
	// transmit mapping and trunk scheduler
	// ----------------------------------------
	// one holding word per port; a newer code group replaces an unsent one,
	// traded for having no buffer beyond the cell register
	lane_s [NPORT-1:0] pend_q;
	logic [2:0] last_q;
	cell_s cell_q;

	wire logic [NPORT-1:0] newWord;
	wire logic [NPORT-1:0] pendReq;
	for (genvar g = 0; g < NPORT; g++) begin : gReq
		assign newWord[g] = rxSync_q[g].valid && !rxPrev_q[g].valid ? 1'b1 :
			rxSync_q[g].valid && (rxSync_q[g].code != rxPrev_q[g].code);
		assign pendReq[g] = pend_q[g].valid && enNow[g];
	end

	wire logic cellFree = !cell_q.valid || utTxClav;
	wire logic [2:0] pick = nextPort(pendReq, last_q);
	wire logic doSend = cellFree && (|pendReq);
	wire logic pickSts = (pick < 3'd2) && isOneGig(proto_q[pick]) &&
		(mode_q == MODE_FC_GE);
	wire logic [1:0] pickChan = !pickSts ? CHAN_GFPT :
		(pick == 3'd0) ? CHAN_STS24_A : CHAN_STS24_B;

	// a port switched off drops its unsent word so a later enable cannot replay it
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pend_q <= '0;
		end else begin
			for (int i = 0; i < NPORT; i++) begin
				if (newWord[i] && enNow[i]) begin
					pend_q[i] <= rxSync_q[i];
				end else if (doSend && pick == 3'(i)) begin
					pend_q[i].valid <= 1'b0;
				end else if (!enNow[i]) begin
					pend_q[i].valid <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			last_q <= 3'h7;
		end else if (doSend) begin
			last_q <= pick;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cell_q <= '0;
		end else if (cellFree) begin
			// single trunk stream carries both STS-24c channels and GFP-T cells
			cell_q <= '{valid: doSend, chan: pickChan, port: pick,
				code: pend_q[pick].code};
		end
	end

	// ----------------------------------------
	// receive chains, monitoring and selection
	// ----------------------------------------
	logic [1:0][LOS_W-1:0] losCnt_q;
	logic [1:0] alive_q;
	logic selMeta_q;
	logic selSync_q;
	wire rxword_s rxPath [2];
	assign rxPath[0] = trunkRxWork;
	assign rxPath[1] = (PROTECTED != 0) ? trunkRxProt : '0;
	wire logic [1:0] rxGood;
	assign rxGood[0] = rxPath[0].valid && rxPath[0].frameOk;
	assign rxGood[1] = rxPath[1].valid && rxPath[1].frameOk;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			losCnt_q <= '0;
			alive_q <= '0;
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (rxGood[p]) begin
					losCnt_q[p] <= '0;
					alive_q[p] <= 1'b1;
				end else if (losCnt_q[p] == LOS_W'(LOS_CYCLES - 1)) begin
					alive_q[p] <= 1'b0;
				end else begin
					losCnt_q[p] <= losCnt_q[p] + LOS_W'(1);
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			selMeta_q <= 1'b0;
			selSync_q <= 1'b0;
		end else begin
			selMeta_q <= pathSelProt;
			selSync_q <= selMeta_q;
		end
	end

	// exactly one path reaches the demapper; protect only in protected build
	wire logic useProt = selSync_q && (PROTECTED != 0);
	wire rxword_s rxSel = useProt ? rxPath[1] : rxPath[0];

	wire logic rxTake = rxSel.valid && rxSel.frameOk;
	wire logic [NPORT-1:0] rxHit;
	for (genvar g = 0; g < NPORT; g++) begin : gHit
		assign rxHit[g] = rxTake && (rxSel.port == 3'(g)) && enNow[g];
	end

	// ----------------------------------------
	// demap toward clients and output registers
	// ----------------------------------------
	logic [NPORT-1:0] txValid_q;
	logic [NPORT-1:0][9:0] txCode_q;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			txValid_q <= '0;
			txCode_q <= '0;
		end else begin
			for (int i = 0; i < NPORT; i++) begin
				txValid_q[i] <= 1'b0;
				if (rxHit[i]) begin
					txValid_q[i] <= 1'b1;
					txCode_q[i] <= rxSel.code;
				end
			end
		end
	end

	logic [NPORT-1:0] portEn_q;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			portEn_q <= '0;
		end else begin
			portEn_q <= enNow;
		end
	end

	assign clientTxValid = txValid_q;
	assign clientTxCode = txCode_q;
	assign utTxCell = cell_q;
	assign pathAlive = alive_q;
	assign portEnable = portEn_q;
	assign activeMode = mode_q;
	assign cfgRejected = rej_q;
endmodule
`default_nettype wire

// [tb/san_client_aggregator_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module san_client_aggregator_checker import san_agg_pkg::*; (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [2:0] cfgMode,
	input wire logic [NPORT-1:0][2:0] cfgProto,
	input wire logic cfgApply,
	input wire logic [NPORT-1:0] clientTxValid,
	input wire logic [NPORT-1:0][9:0] clientTxCode,
	input wire cell_s utTxCell,
	input wire logic utTxClav,
	input wire rxword_s trunkRxWork,
	input wire rxword_s trunkRxProt,
	input wire logic pathSelProt,
	input wire logic [NPORT-1:0] portEnable,
	input wire logic [2:0] activeMode,
	input wire logic cfgRejected
);
	// ----------------------------------------
	// port protocol rules
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire logic allLow = cfgProto == {NPORT{3'h6}};
	wire logic okMode = cfgMode inside {3'h1, 3'h2, 3'h4};
	a_cell_hold: assert property (utTxCell.valid && !utTxClav |=> $stable(utTxCell))
		else $error("cell moved while stalled");
	a_bad_mode: assert property (cfgApply && !okMode |=> cfgRejected)
		else $error("bad mode taken");
	a_all_low: assert property (cfgApply && cfgMode == MODE_ALL_LRMC && allLow |=>
		!cfgRejected && activeMode == MODE_ALL_LRMC) else $error("all low-rate refused");
	a_port_locked: assert property (cfgApply && !(cfgProto[2] inside {3'h0, 3'h6})
		|=> cfgRejected) else $error("port 3 proto taken");
	a_rate_cap: assert property (cfgApply && cfgProto[0] == PROTO_FC2
		&& cfgProto[1] == PROTO_GE |=> cfgRejected) else $error("trunk oversubscribed");
	a_rx_demap: assert property ((!pathSelProt)[*4] ##0 (trunkRxWork.valid
		&& trunkRxWork.frameOk && portEnable[trunkRxWork.port]) |=>
		clientTxValid[$past(trunkRxWork.port)]
		&& clientTxCode[$past(trunkRxWork.port)] == $past(trunkRxWork.code))
		else $error("rx word lost");
	a_one_path: assert property (pathSelProt[*4] ##0 (!trunkRxProt.valid)
		|=> clientTxValid == '0) else $error("unselected path leaked");
	a_chan_b: assert property (utTxCell.valid && utTxCell.chan == CHAN_STS24_B |->
		utTxCell.port == 3'h1 && activeMode == MODE_FC_GE) else $error("bad second channel");
	c_cfg_ok: cover property (cfgApply ##1 !cfgRejected);
	c_cell: cover property (utTxCell.valid && utTxClav);
	c_rx: cover property (|clientTxValid);
endmodule
bind san_client_aggregator san_client_aggregator_checker u_chk (.*);
`default_nettype wire

// [tb/san_framer_model.sv]
`timescale 1ns/1ps
`default_nettype none
module san_framer_model import san_agg_pkg::*; (
	input wire logic core_clk,
	input wire logic nrst,
	input wire cell_s utTxCell,
	input wire logic slow,
	output logic utTxClav,
	output rxword_s trunkRxWork,
	output rxword_s trunkRxProt
);
	// ----------------------------------------
	// framer side
	// ----------------------------------------
	cell_s lastCell;
	int cellCount;
	logic [1:0] tick;
	// a slow framer takes one cell in four, so stalls hit the hold rule
	assign utTxClav = !slow || tick == 2'h0;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tick <= '0;
			cellCount <= 0;
		end else begin
			tick <= tick + 2'h1;
			if (utTxCell.valid && utTxClav) begin
				lastCell <= utTxCell;
				cellCount <= cellCount + 1;
			end
		end
	end
	initial begin
		trunkRxWork = '0;
		trunkRxProt = '0;
	end
	// after a word the lines show inverted junk, not the old value
	task automatic sendRx(input bit prot, input logic [2:0] port, input logic [9:0] code);
		rxword_s w;
		w = '{1'b1, 1'b1, port, code};
		if (prot) trunkRxProt = w;
		else trunkRxWork = w;
		@(posedge core_clk);
		#1;
		w = '{1'b0, 1'b0, ~port, ~code};
		if (prot) trunkRxProt = w;
		else trunkRxWork = w;
	endtask
endmodule
`default_nettype wire

// [tb/multirate_san_client_aggregator_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module multirate_san_client_aggregator_tb import san_agg_pkg::*; ;
	logic core_clk = 0, nrst = 0, cfgApply = 0, pathSelProt = 0, slow = 0, utTxClav;
	logic [2:0] cfgMode = 3'h1;
	logic [NPORT-1:0][2:0] cfgProto = '0;
	logic [NPORT-1:0] clientRxValid = '0, clientTxValid, portEnable;
	logic [NPORT-1:0][9:0] clientRxCode = '0, clientTxCode;
	cell_s utTxCell;
	rxword_s trunkRxWork, trunkRxProt;
	logic [1:0] pathAlive;
	logic [2:0] activeMode;
	logic cfgRejected;
	int miscompares = 0, numChecks = 0, cycles = 0;
	san_client_aggregator u_dut (.*);
	san_framer_model u_far (.*);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	initial forever #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			end_of_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", numChecks, miscompares);
		if (miscompares == 0 && numChecks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic apply(input logic [2:0] m, input logic [NPORT-1:0][2:0] p, input logic rej);
		cfgMode = m;
		cfgProto = p;
		cfgApply = 1;
		tick(1);
		cfgApply = 0;
		tick(1);
		chk("rejected", cfgRejected, rej);
		tick(1);
	endtask
	task automatic txOne(input int pt, input logic [9:0] code, input logic [1:0] ch);
		int n;
		n = u_far.cellCount;
		clientRxValid[pt] = 1;
		clientRxCode[pt] = code;
		for (int i = 0; i < 60 && u_far.cellCount == n; i++) tick(1);
		chk("cell", u_far.lastCell, {1'b1, ch, 3'(pt), code});
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic test_config();
		logic [NPORT-1:0][2:0] p;
		apply(MODE_ALL_LRMC, {NPORT{PROTO_LRMC}}, 0);
		chk("mode", activeMode, MODE_ALL_LRMC);
		chk("enable", portEnable, 8'hff);
		apply(3'h3, {NPORT{PROTO_LRMC}}, 1);
		chk("mode", activeMode, MODE_ALL_LRMC);
		p = '0;
		p[2] = PROTO_GE;
		apply(MODE_FC_GE, p, 1);
		p = '0;
		p[0] = PROTO_FC2;
		p[1] = PROTO_GE;
		apply(MODE_FC_GE, p, 1);
		p = {{4{PROTO_LRMC}}, 9'h0, PROTO_GE};
		apply(MODE_MIXED, p, 0);
		chk("enable", portEnable, 8'hf1);
		p[1] = PROTO_GE;
		apply(MODE_MIXED, p, 1);
		for (int c = 1; c < 7; c++) begin
			p = '0;
			p[1] = 3'(c);
			apply(MODE_FC_GE, p, 0);
			chk("enable", portEnable, 8'h02);
		end
		$display("test config done");
	endtask
	task automatic test_tx();
		logic [NPORT-1:0][2:0] p;
		p = '0;
		p[0] = PROTO_FC1;
		p[1] = PROTO_MFFC1;
		apply(MODE_FC_GE, p, 0);
		slow = 1;
		txOne(0, 10'h17c, CHAN_STS24_A);
		txOne(1, 10'h283, CHAN_STS24_B);
		txOne(0, 10'h0f9, CHAN_STS24_A);
		tick(20);
		clientRxValid[3] = 1;
		tick(20);
		chk("count", u_far.cellCount, 3);
		p[2] = PROTO_LRMC;
		apply(MODE_FC_GE, p, 0);
		txOne(2, 10'h2e1, CHAN_GFPT);
		p[0] = PROTO_GE;
		apply(MODE_FC_GE, p, 1);
		p[2] = PROTO_NONE;
		apply(MODE_FC_GE, p, 0);
		txOne(0, 10'h1e2, CHAN_STS24_A);
		slow = 0;
		$display("test tx done");
	endtask
	task automatic test_rx();
		logic [NPORT-1:0][2:0] p;
		p = '0;
		p[0] = PROTO_GE;
		p[1] = PROTO_GE;
		apply(MODE_FC_GE, p, 0);
		u_far.sendRx(0, 3'h0, 10'h155);
		chk("txValid", clientTxValid, 8'h01);
		chk("txCode", clientTxCode[0], 10'h155);
		u_far.sendRx(1, 3'h1, 10'h2aa);
		chk("txValid", clientTxValid, 8'h00);
		chk("alive", pathAlive, 2'h3);
		pathSelProt = 1;
		tick(4);
		u_far.sendRx(1, 3'h1, 10'h0c3);
		chk("txValid", clientTxValid, 8'h02);
		chk("txCode", clientTxCode[1], 10'h0c3);
		u_far.sendRx(0, 3'h0, 10'h33c);
		chk("txValid", clientTxValid, 8'h00);
		tick(LOS_CYCLES + 2);
		chk("alive", pathAlive, 2'h0);
		$display("test rx done");
	endtask
	initial begin
		tick(8);
		nrst = 1;
		tick(1);
		test_config();
		test_tx();
		test_rx();
		end_of_test();
	end
endmodule
`default_nettype wire
